// File: include/lbc_pkg.sv
// package for the led bank boost controller: register map, fields, resets, timing
// assumes a 20 MHz core clock and an apb slave with an 8-bit byte address

package lbc_pkg;

  // ************************************************************
  // register byte addresses
  // ************************************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SINK_MAP = 8'h04;
  localparam logic [7:0] ADDR_FB_EN = 8'h08;
  localparam logic [7:0] ADDR_BOOST = 8'h0c;
  localparam logic [7:0] ADDR_AUTO_THR = 8'h10;
  localparam logic [7:0] ADDR_PWM_CFG = 8'h14;
  localparam logic [7:0] ADDR_A_FS = 8'h18;
  localparam logic [7:0] ADDR_A_LSB = 8'h1c;
  localparam logic [7:0] ADDR_A_MSB = 8'h20;
  localparam logic [7:0] ADDR_B_FS = 8'h24;
  localparam logic [7:0] ADDR_B_LSB = 8'h28;
  localparam logic [7:0] ADDR_B_MSB = 8'h2c;
  localparam logic [7:0] ADDR_STATUS = 8'h30;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h34;
  localparam logic [7:0] ADDR_STATE = 8'h38;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int CTRL_A_EN = 0;
  localparam int CTRL_B_EN = 1;
  localparam int BOOST_FREQ = 0;
  localparam int BOOST_AUTO = 3;
  localparam int PWM_TO_A = 0;
  localparam int PWM_TO_B = 1;
  localparam int PWM_LOW = 2;
  localparam int PWM_ZD_OFF = 3;
  localparam int ST_THERM_ON = 3;
  localparam int ST_THERM_OFF = 4;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [2:0] SINK_MAP_RST = 3'h0;
  localparam logic [2:0] FB_EN_RST = 3'h7;
  localparam logic [3:0] BOOST_RST = 4'h0;
  localparam logic [7:0] AUTO_THR_RST = 8'h00;
  localparam logic [3:0] PWM_CFG_RST = 4'h0;
  localparam logic [4:0] FS_RST = 5'h00;
  localparam logic [2:0] LSB_RST = 3'h0;
  localparam logic [7:0] MSB_RST = 8'h00;
  localparam logic [4:0] STATUS_RST = 5'h00;
  localparam logic [4:0] MASK_RST = 5'h00;

  // ************************************************************
  // timing and duty scale
  // ************************************************************
  localparam int CLK_PERIOD_NS = 50;
  localparam int MIN_PULSE_NS = 750;
  localparam int MIN_PULSE_CYC = (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DUTY_WIN_LOG2 = 14;
  localparam logic [8:0] DUTY_ONE = 9'h100;
  localparam logic [8:0] NEAR_ZERO_DUTY = 9'h002;

  // thermal reaction state
  typedef enum logic {
    LBC_TS_RUN = 1'b0,
    LBC_TS_HOT = 1'b1
  } lbc_therm_t;

endpackage

// File: verilog/lbc_pwm_meter.sv
// duty meter for the synchronised pwm level, with near-zero pulse rejection
// assumes pwm_i is already synchronised and polarity-corrected

module lbc_pwm_meter #(
  parameter int unsigned WIN_LOG2 = lbc_pkg::DUTY_WIN_LOG2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clear_i,
  input wire logic pwm_i,
  input wire logic zd_en_i,
  output logic [8:0] duty_o,
  output logic near_zero_o
);
  import lbc_pkg::*;

  // ************************************************************
  // window and pulse counting
  // ************************************************************
  logic [WIN_LOG2-1:0] win_q;
  logic [WIN_LOG2:0] acc_q;
  logic [WIN_LOG2:0] run_q;
  logic pwm_d1_q;
  logic [8:0] duty_q;
  logic near_zero_q;

  wire fall = pwm_d1_q & ~pwm_i;
  wire win_end = &win_q;
  // once near zero was seen, short pulses no longer move the current
  wire accept = ~(zd_en_i & near_zero_q) || (run_q >= (WIN_LOG2+1)'(MIN_PULSE_CYC));
  wire add_run = (fall | (win_end & pwm_i)) & accept;
  // a pulse still high at the window end owns the current cycle too, else it is lost
  wire [WIN_LOG2:0] run_cnt = run_q + {{WIN_LOG2{1'b0}}, pwm_i};
  wire [WIN_LOG2:0] sum = add_run ? acc_q + run_cnt : acc_q;

  // pulse lengths are added when each pulse ends or the window ends, so the rejection sees only the part of a pulse inside one window
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      win_q <= '0;
      acc_q <= '0;
      run_q <= '0;
      pwm_d1_q <= 1'b0;
    end else if (clear_i) begin
      win_q <= '0;
      acc_q <= '0;
      run_q <= '0;
      pwm_d1_q <= 1'b0;
    end else begin
      win_q <= win_q + 1'b1;
      pwm_d1_q <= pwm_i;
      acc_q <= win_end ? '0 : sum;
      run_q <= (win_end | ~pwm_i) ? '0 : run_q + 1'b1;
    end
  end

  // duty in 1/256 steps, 256 meaning full; an early window end splits long pulses
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      duty_q <= 9'h000;
      near_zero_q <= 1'b1;
    end else if (clear_i) begin
      duty_q <= 9'h000;
      near_zero_q <= 1'b1;
    end else if (win_end) begin
      duty_q <= sum[WIN_LOG2 -: 9];
      near_zero_q <= sum[WIN_LOG2 -: 9] < NEAR_ZERO_DUTY;
    end
  end

  assign duty_o = duty_q;
  assign near_zero_o = near_zero_q;

endmodule // lbc_pwm_meter

// File: verilog/lbc_top.sv
// led bank boost controller: apb registers, bank/sink control, boost frequency, faults
// assumes apb master on core_clk_i; enable, pwm, thermal and short pins are asynchronous
//
// Behaviour
// - routed pwm duty scales bank, else one
// - enable pin low: shutdown, registers default
// - over-temperature turns boost, sinks off until cool
// - each bank: 5-bit full-scale, 11-bit brightness
// - sink-to-bank mapping from output configuration register
// - feedback enables [2:0] default one
// - short fault flag gated by feedback enable
// - boost control bit 0 selects frequency
// - select zero 500 kHz, one 1 MHz
// - boost control bit 3 enables auto frequency
// - auto compares threshold with brightness upper byte
// - above threshold 1 MHz, else 500 kHz
// - near-zero detect ignores pulses under 0.75 us

module lbc_top #(
  parameter int unsigned DUTY_WIN_LOG2 = lbc_pkg::DUTY_WIN_LOG2
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic global_enable_pin_i,
  input wire logic pwm_pin_i,
  input wire logic temp_hot_i,
  input wire logic temp_cool_i,
  input wire logic [2:0] sink_short_i,
  output logic boost_en_o,
  output logic boost_freq_1mhz_o,
  output logic [2:0] sink_en_o,
  output logic [2:0] sink_bank_b_o,
  output logic [2:0] sink_fb_en_o,
  output logic [4:0] bank_a_fs_o,
  output logic [4:0] bank_b_fs_o,
  output logic [10:0] bank_a_level_o,
  output logic [10:0] bank_b_level_o,
  output logic irq_o
);
  import lbc_pkg::*;

  // ************************************************************
  // helpers
  // ************************************************************
  // brightness times duty, where duty 256 stands for one
  function automatic logic [10:0] scale_level(logic [10:0] b, logic [8:0] d);
    logic [19:0] p;
    p = 20'(b) * 20'(d);
    return p[18:8];
  endfunction

  function automatic logic [7:0] max8(logic [7:0] x, logic [7:0] y);
    return (x > y) ? x : y;
  endfunction

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [6:0] sync1_q;
  logic [6:0] sync2_q;

  // first stage feeds only the second stage
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_q <= 7'h00;
      sync2_q <= 7'h00;
    end else begin
      sync1_q <= {global_enable_pin_i, pwm_pin_i, temp_hot_i, temp_cool_i, sink_short_i};
      sync2_q <= sync1_q;
    end
  end

  wire en_s = sync2_q[6];
  wire pwm_s = sync2_q[5];
  wire hot_s = sync2_q[4];
  wire cool_s = sync2_q[3];
  wire [2:0] short_s = sync2_q[2:0];
  // registers are held at default while the enable pin is low
  wire clr = ~en_s;

  // ************************************************************
  // apb decode
  // ************************************************************
  logic [1:0] ctrl_q;
  logic [2:0] sink_map_q;
  logic [2:0] fb_en_q;
  logic [3:0] boost_q;
  logic [7:0] auto_thr_q;
  logic [3:0] pwm_cfg_q;
  logic [4:0] a_fs_q;
  logic [4:0] b_fs_q;
  logic [2:0] a_lsb_q;
  logic [2:0] b_lsb_q;
  logic [10:0] a_bright_q;
  logic [10:0] b_bright_q;
  logic [4:0] status_q;
  logic [4:0] mask_q;
  logic [31:0] prdata_q;
  logic [31:0] rdata;
  logic pready_q;
  logic pslverr_q;
  logic [8:0] duty;
  logic near_zero;
  lbc_therm_t therm_q;

  wire setup = psel_i & ~penable_i;
  wire wr = psel_i & penable_i & pready_q & pwrite_i;
  wire hit_ctrl = paddr_i == ADDR_CTRL;
  wire hit_map = paddr_i == ADDR_SINK_MAP;
  wire hit_fb = paddr_i == ADDR_FB_EN;
  wire hit_boost = paddr_i == ADDR_BOOST;
  wire hit_thr = paddr_i == ADDR_AUTO_THR;
  wire hit_pwm = paddr_i == ADDR_PWM_CFG;
  wire hit_afs = paddr_i == ADDR_A_FS;
  wire hit_alsb = paddr_i == ADDR_A_LSB;
  wire hit_amsb = paddr_i == ADDR_A_MSB;
  wire hit_bfs = paddr_i == ADDR_B_FS;
  wire hit_blsb = paddr_i == ADDR_B_LSB;
  wire hit_bmsb = paddr_i == ADDR_B_MSB;
  wire hit_stat = paddr_i == ADDR_STATUS;
  wire hit_mask = paddr_i == ADDR_IRQ_MASK;
  wire hit_state = paddr_i == ADDR_STATE;

  // read mux; unmapped reads return zero with an error
  always_comb begin
    rdata = 32'h0000_0000;
    if (hit_ctrl) begin
      rdata = 32'(ctrl_q);
    end else if (hit_map) begin
      rdata = 32'(sink_map_q);
    end else if (hit_fb) begin
      rdata = 32'(fb_en_q);
    end else if (hit_boost) begin
      rdata = 32'(boost_q);
    end else if (hit_thr) begin
      rdata = 32'(auto_thr_q);
    end else if (hit_pwm) begin
      rdata = 32'(pwm_cfg_q);
    end else if (hit_afs) begin
      rdata = 32'(a_fs_q);
    end else if (hit_alsb) begin
      rdata = 32'(a_lsb_q);
    end else if (hit_amsb) begin
      rdata = 32'(a_bright_q[10:3]);
    end else if (hit_bfs) begin
      rdata = 32'(b_fs_q);
    end else if (hit_blsb) begin
      rdata = 32'(b_lsb_q);
    end else if (hit_bmsb) begin
      rdata = 32'(b_bright_q[10:3]);
    end else if (hit_stat) begin
      rdata = 32'(status_q);
    end else if (hit_mask) begin
      rdata = 32'(mask_q);
    end else if (hit_state) begin
      rdata = {7'h00, duty, 13'h0000, near_zero, boost_freq_1mhz_o, therm_q};
    end
  end

  wire mapped = hit_ctrl | hit_map | hit_fb | hit_boost | hit_thr | hit_pwm | hit_afs |
                hit_alsb | hit_amsb | hit_bfs | hit_blsb | hit_bmsb | hit_stat | hit_mask |
                hit_state;

  // answer one cycle after setup, so every access has no wait state
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup & ~mapped;
      prdata_q <= (setup & ~pwrite_i) ? rdata : 32'h0000_0000;
    end
  end

  // ************************************************************
  // configuration registers
  // ************************************************************
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_q <= CTRL_RST;
      sink_map_q <= SINK_MAP_RST;
      fb_en_q <= FB_EN_RST;
      boost_q <= BOOST_RST;
      auto_thr_q <= AUTO_THR_RST;
      pwm_cfg_q <= PWM_CFG_RST;
      mask_q <= MASK_RST;
    end else if (clr) begin
      ctrl_q <= CTRL_RST;
      sink_map_q <= SINK_MAP_RST;
      fb_en_q <= FB_EN_RST;
      boost_q <= BOOST_RST;
      auto_thr_q <= AUTO_THR_RST;
      pwm_cfg_q <= PWM_CFG_RST;
      mask_q <= MASK_RST;
    end else if (wr) begin
      if (hit_ctrl) ctrl_q <= pwdata_i[1:0];
      if (hit_map) sink_map_q <= pwdata_i[2:0];
      if (hit_fb) fb_en_q <= pwdata_i[2:0];
      if (hit_boost) boost_q <= pwdata_i[3:0];
      if (hit_thr) auto_thr_q <= pwdata_i[7:0];
      if (hit_pwm) pwm_cfg_q <= pwdata_i[3:0];
      if (hit_mask) mask_q <= pwdata_i[4:0];
    end
  end

  // bank settings; the low bits wait until the upper byte is written
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      a_fs_q <= FS_RST;
      b_fs_q <= FS_RST;
      a_lsb_q <= LSB_RST;
      b_lsb_q <= LSB_RST;
      a_bright_q <= {MSB_RST, LSB_RST};
      b_bright_q <= {MSB_RST, LSB_RST};
    end else if (clr) begin
      a_fs_q <= FS_RST;
      b_fs_q <= FS_RST;
      a_lsb_q <= LSB_RST;
      b_lsb_q <= LSB_RST;
      a_bright_q <= {MSB_RST, LSB_RST};
      b_bright_q <= {MSB_RST, LSB_RST};
    end else if (wr) begin
      if (hit_afs) a_fs_q <= pwdata_i[4:0];
      if (hit_bfs) b_fs_q <= pwdata_i[4:0];
      if (hit_alsb) a_lsb_q <= pwdata_i[2:0];
      if (hit_blsb) b_lsb_q <= pwdata_i[2:0];
      if (hit_amsb) a_bright_q <= {pwdata_i[7:0], a_lsb_q};
      if (hit_bmsb) b_bright_q <= {pwdata_i[7:0], b_lsb_q};
    end
  end

  // ************************************************************
  // thermal shutdown
  // ************************************************************
  // hysteresis: trip on the hot comparator, release only on the cool one
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      therm_q <= LBC_TS_RUN;
    end else begin
      case (therm_q)
        LBC_TS_RUN: if (hot_s) therm_q <= LBC_TS_HOT;
        LBC_TS_HOT: if (cool_s && !hot_s) therm_q <= LBC_TS_RUN;
        default: therm_q <= LBC_TS_RUN;
      endcase
    end
  end

  wire therm_enter = (therm_q == LBC_TS_RUN) & hot_s;
  wire therm_leave = (therm_q == LBC_TS_HOT) & cool_s & ~hot_s;

  // ************************************************************
  // status and interrupt
  // ************************************************************
  // a short only counts on sinks that sit in the feedback loop
  wire [4:0] events = {therm_leave, therm_enter, short_s & fb_en_q};
  wire [4:0] w1c = (wr & hit_stat) ? pwdata_i[4:0] : 5'h00;

  // a new event wins over a clear in the same cycle
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      status_q <= STATUS_RST;
      irq_o <= 1'b0;
    end else if (clr) begin
      status_q <= STATUS_RST;
      irq_o <= 1'b0;
    end else begin
      status_q <= (status_q & ~w1c) | events;
      irq_o <= |(((status_q & ~w1c) | events) & mask_q);
    end
  end

  // ************************************************************
  // pwm duty and bank levels
  // ************************************************************
  wire pwm_used = pwm_cfg_q[PWM_TO_A] | pwm_cfg_q[PWM_TO_B];
  wire pwm_lvl = pwm_s ^ pwm_cfg_q[PWM_LOW];

  lbc_pwm_meter #(
    .WIN_LOG2(DUTY_WIN_LOG2)
  ) u_meter (
    .clk_i(core_clk_i),
    .rst_i(rst_i),
    .clear_i(clr | ~pwm_used),
    .pwm_i(pwm_lvl),
    .zd_en_i(~pwm_cfg_q[PWM_ZD_OFF]),
    .duty_o(duty),
    .near_zero_o(near_zero)
  );

  // an unrouted bank sees a duty of one
  wire [8:0] a_duty = pwm_cfg_q[PWM_TO_A] ? duty : DUTY_ONE;
  wire [8:0] b_duty = pwm_cfg_q[PWM_TO_B] ? duty : DUTY_ONE;
  wire run = ~clr & (therm_q == LBC_TS_RUN);
  wire a_on = ctrl_q[CTRL_A_EN] & run;
  wire b_on = ctrl_q[CTRL_B_EN] & run;
  wire [2:0] sink_on = {sink_map_q[2] ? b_on : a_on, sink_map_q[1] ? b_on : a_on,
                        sink_map_q[0] ? b_on : a_on};

  // ************************************************************
  // boost frequency
  // ************************************************************
  // only active banks take part; the larger upper byte decides
  wire [7:0] a_code = a_on ? a_bright_q[10:3] : 8'h00;
  wire [7:0] b_code = b_on ? b_bright_q[10:3] : 8'h00;
  wire [7:0] cmp_code = max8(a_code, b_code);
  wire auto_fast = cmp_code > auto_thr_q;
  // fixed select: zero is 500 kHz, one is 1 MHz
  wire freq_d = boost_q[BOOST_AUTO] ? auto_fast : boost_q[BOOST_FREQ];

  // drive outputs from flops; thermal and enable shutdown drop boost and sink enables together
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      boost_en_o <= 1'b0;
      boost_freq_1mhz_o <= 1'b0;
      sink_en_o <= 3'h0;
      bank_a_level_o <= 11'h000;
      bank_b_level_o <= 11'h000;
    end else begin
      boost_en_o <= a_on | b_on;
      boost_freq_1mhz_o <= freq_d;
      sink_en_o <= sink_on;
      bank_a_level_o <= scale_level(a_bright_q, a_duty);
      bank_b_level_o <= scale_level(b_bright_q, b_duty);
    end
  end

  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;
  assign sink_bank_b_o = sink_map_q;
  assign sink_fb_en_o = fb_en_q;
  assign bank_a_fs_o = a_fs_q;
  assign bank_b_fs_o = b_fs_q;

endmodule // lbc_top

// File: dv/lbc_pwm_src.sv
// duty source that stands in for the external pwm driver
// assumes the bench sets the high time in core cycles; the period is fixed
module lbc_pwm_src #(
  parameter int PERIOD = 256
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [8:0] high_cyc_i,
  output logic pwm_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [8:0] cnt_q;
  // high for the first high_cyc_i cycles of each period
  // short pulses stay short: rejecting them is the meter's job
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= 9'h000;
      pwm_o <= 1'b0;
    end else begin
      cnt_q <= (cnt_q == 9'(PERIOD - 1)) ? 9'h000 : cnt_q + 9'h001;
      pwm_o <= (cnt_q < high_cyc_i);
    end
  end
endmodule // lbc_pwm_src

// File: dv/lbc_top_monitor.sv
// port checker for the led bank boost controller
// assumes it is bound into lbc_top and sees only its ports
module lbc_top_monitor (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic global_enable_pin_i,
  input wire logic temp_hot_i,
  input wire logic temp_cool_i,
  input wire logic [2:0] sink_short_i,
  input wire logic boost_en_o,
  input wire logic boost_freq_1mhz_o,
  input wire logic [2:0] sink_en_o,
  input wire logic [2:0] sink_fb_en_o,
  input wire logic [4:0] bank_a_fs_o,
  input wire logic irq_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking mon_cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // ************************************************************
  // assertions
  // ************************************************************
  AST_READY_AFTER_SETUP: assert property (psel_i && !penable_i |=> pready_o)
    else $error("no ready one cycle after setup");
  AST_READY_ONE: assert property (pready_o |=> !pready_o)
    else $error("ready held longer than one cycle");
  AST_RDATA_IDLE: assert property (!pready_o |-> prdata_o == 32'h0 && !pslverr_o)
    else $error("read data or error outside access cycle");
  AST_FB_DEFAULT: assert property ($fell(rst_i) |-> sink_fb_en_o == 3'h7 && !irq_o)
    else $error("feedback enables not all set after reset");
  // pin low long enough: feedback enables, bank a full-scale, sinks, boost and irq back at default
  AST_SHUTDOWN: assert property (!global_enable_pin_i [*7] |->
    sink_fb_en_o == 3'h7 && bank_a_fs_o == 5'h00 && sink_en_o == 3'h0 && !boost_en_o && !irq_o)
    else $error("enable pin low but outputs not at default");
  AST_THERMAL: assert property (temp_hot_i [*6] |-> !boost_en_o && sink_en_o == 3'h0)
    else $error("boost or sinks on while hot");
  AST_SINK_NEEDS_BOOST: assert property (|sink_en_o |-> boost_en_o)
    else $error("sink on without boost");
  // an interrupt only rises after a register write or a synced pin event
  AST_IRQ_CAUSE: assert property ($rose(irq_o) |-> $past(pwrite_i && penable_i, 2) ||
    $past(|sink_short_i || temp_hot_i || temp_cool_i, 3))
    else $error("interrupt rose without cause");
  // ************************************************************
  // covers
  // ************************************************************
  COV_SLVERR: cover property (pslverr_o);
  COV_IRQ: cover property ($rose(irq_o));
  COV_FAST: cover property ($rose(boost_freq_1mhz_o));
endmodule // lbc_top_monitor

// File: dv/tb_led_bank_boost_control.sv
// self-checking bench for the led bank boost controller
// assumes lbc_pkg, lbc_top, lbc_pwm_src and lbc_top_monitor are compiled first
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module tb_led_bank_boost_control import lbc_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst, psel, pen, pwr, en, hot, cool, rerr, pready, pslverr, pwm, boost_en, freq, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, rdat, prdata;
  logic [2:0] shorts, sink_en, bank_b, fb_en;
  logic [8:0] pwm_high;
  logic [4:0] a_fs, b_fs;
  logic [10:0] a_lvl, b_lvl;
  int failures, num_checks, cyc;
  lbc_pwm_src u_pwm (.clk_i(clk), .rst_i(rst), .high_cyc_i(pwm_high), .pwm_o(pwm));
  // short duty windows keep the pwm scenarios brief
  lbc_top #(.DUTY_WIN_LOG2(8)) dut (.core_clk_i(clk), .rst_i(rst), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .global_enable_pin_i(en), .pwm_pin_i(pwm),
    .temp_hot_i(hot), .temp_cool_i(cool), .sink_short_i(shorts), .boost_en_o(boost_en),
    .boost_freq_1mhz_o(freq), .sink_en_o(sink_en), .sink_bank_b_o(bank_b),
    .sink_fb_en_o(fb_en), .bank_a_fs_o(a_fs), .bank_b_fs_o(b_fs), .bank_a_level_o(a_lvl),
    .bank_b_level_o(b_lvl), .irq_o(irq));
  // ************************************************************
  // bus and helper tasks
  // ************************************************************
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  // one apb transfer; request held until ready is sampled, then an idle cycle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    // no wait state expected; a hang is ended by the bench timeout only
    while (pready !== 1'b1) begin
      n++;
      @(posedge clk);
    end
    `CHK(n, 0)
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rdat, e)
  endtask
  task automatic give_verdict();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_regs();
    rchk(ADDR_FB_EN, 32'h7);
    `CHK(fb_en, FB_EN_RST)
    rchk(8'h3c, 32'h0);
    `CHK(rerr, 1'b1)
  endtask
  task automatic t_banks();
    apb(1'b1, ADDR_CTRL, 32'h3);
    apb(1'b1, ADDR_SINK_MAP, 32'h5);
    apb(1'b1, ADDR_A_FS, 32'h1f);
    apb(1'b1, ADDR_A_LSB, 32'h5);
    wt(3);
    `CHK(a_lvl, 11'h000)
    apb(1'b1, ADDR_A_MSB, 32'ha5);
    apb(1'b1, ADDR_B_FS, 32'h0a);
    apb(1'b1, ADDR_B_MSB, 32'h40);
    wt(3);
    `CHK({a_lvl, b_lvl}, {11'h52d, 11'h200})
    `CHK({a_fs, b_fs}, {5'h1f, 5'h0a})
    `CHK({bank_b, sink_en}, {3'h5, 3'h7})
  endtask
  task automatic t_freq();
    apb(1'b1, ADDR_BOOST, 32'h1);
    wt(3);
    `CHK(freq, 1'b1)
    apb(1'b1, ADDR_BOOST, 32'h0);
    wt(3);
    `CHK(freq, 1'b0)
    apb(1'b1, ADDR_AUTO_THR, 32'ha5);
    apb(1'b1, ADDR_BOOST, 32'h9);
    wt(3);
    `CHK(freq, 1'b0)
    apb(1'b1, ADDR_AUTO_THR, 32'ha4);
    wt(3);
    `CHK(freq, 1'b1)
    apb(1'b1, ADDR_AUTO_THR, 32'ha5);
    apb(1'b1, ADDR_B_MSB, 32'ha6);
    wt(3);
    `CHK(freq, 1'b1)
    apb(1'b1, ADDR_BOOST, 32'h0);
    apb(1'b1, ADDR_B_MSB, 32'h40);
  endtask
  // sink 0 out of the loop, sink 2 masked: no interrupt until the mask opens
  task automatic t_short();
    apb(1'b1, ADDR_FB_EN, 32'h6);
    apb(1'b1, ADDR_IRQ_MASK, 32'h3);
    shorts <= 3'h5;
    wt(8);
    `CHK(irq, 1'b0)
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK(rdat[2:0], 3'h4)
    apb(1'b1, ADDR_IRQ_MASK, 32'h7);
    wt(2);
    `CHK(irq, 1'b1)
    shorts <= 3'h0;
    wt(8);
    apb(1'b1, ADDR_STATUS, 32'h4);
    wt(2);
    `CHK(irq, 1'b0)
  endtask
  task automatic t_pwm();
    pwm_high <= 9'd128;
    apb(1'b1, ADDR_PWM_CFG, 32'h1);
    wt(1024);
    `CHK(a_lvl, 11'(32'h52d * 128 / 256))
    pwm_high <= 9'd0;
    wt(600);
    pwm_high <= 9'd10;
    wt(600);
    `CHK(a_lvl, 11'h000)
    apb(1'b1, ADDR_PWM_CFG, 32'h9);
    wt(600);
    `CHK(a_lvl, 11'(32'h52d * 10 / 256))
    // active-low input: the low time of the pin becomes the duty
    apb(1'b1, ADDR_PWM_CFG, 32'hd);
    wt(600);
    `CHK(a_lvl, 11'(32'h52d * 246 / 256))
    apb(1'b1, ADDR_PWM_CFG, 32'h0);
    wt(3);
    `CHK(a_lvl, 11'h52d)
  endtask
  task automatic t_therm();
    hot <= 1'b1;
    cool <= 1'b0;
    wt(8);
    `CHK({boost_en, sink_en}, 4'h0)
    hot <= 1'b0;
    wt(8);
    `CHK({boost_en, sink_en}, 4'h0)
    cool <= 1'b1;
    wt(8);
    `CHK({boost_en, sink_en}, 4'hf)
  endtask
  // a write while the pin is low must be lost as well
  task automatic t_off();
    en <= 1'b0;
    wt(8);
    `CHK({sink_en, a_fs, fb_en}, {3'h0, 5'h00, 3'h7})
    apb(1'b1, ADDR_SINK_MAP, 32'h7);
    en <= 1'b1;
    wt(400);
    rchk(ADDR_CTRL, 32'h0);
    rchk(ADDR_SINK_MAP, 32'h0);
    rchk(ADDR_FB_EN, 32'h7);
    rchk(ADDR_A_MSB, 32'h0);
  endtask
  // ************************************************************
  // clock, timeout and main sequence
  // ************************************************************
  always #25 clk = ~clk;
  // a hang ends the run as a failure
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      $display("[ERR] %0t timeout", $time);
      give_verdict();
    end
  end
  initial begin
    {clk, psel, pen, pwr, hot, rerr} = 6'h00;
    {rst, en, cool} = 3'h7;
    {paddr, pwdata, rdat, shorts, pwm_high} = 84'h0;
    {failures, num_checks, cyc} = 96'h0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    wt(400);
    t_regs();
    t_banks();
    t_freq();
    t_short();
    t_pwm();
    t_therm();
    t_off();
    give_verdict();
  end
endmodule // tb_led_bank_boost_control
bind lbc_top lbc_top_monitor mon (.core_clk_i(core_clk_i), .rst_i(rst_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .global_enable_pin_i(global_enable_pin_i), .temp_hot_i(temp_hot_i),
  .temp_cool_i(temp_cool_i), .sink_short_i(sink_short_i), .boost_en_o(boost_en_o),
  .boost_freq_1mhz_o(boost_freq_1mhz_o), .sink_en_o(sink_en_o), .sink_fb_en_o(sink_fb_en_o),
  .bank_a_fs_o(bank_a_fs_o), .irq_o(irq_o));
